// ===== hw/dptc_pkg.sv
// Purpose: Shared constants for the dual port timestamp capture unit.
// Assumes: 8-bit register port, 20 MHz device clock.
// Notes: Offsets are byte addresses on the plain register port.
package dptc_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] DPTC_OFS_CONFIG = 8'h25;
    localparam logic [7:0] DPTC_OFS_CONTROL = 8'h26;
    localparam logic [7:0] DPTC_OFS_LINE_UPPER = 8'h27;
    localparam logic [7:0] DPTC_OFS_LINE_LOWER = 8'h28;
    localparam logic [7:0] DPTC_OFS_STATUS = 8'h29;
    localparam logic [7:0] DPTC_OFS_P0_UPPER = 8'h2a;
    localparam logic [7:0] DPTC_OFS_P0_LOWER = 8'h2b;
    localparam logic [7:0] DPTC_OFS_P1_UPPER = 8'h2c;
    localparam logic [7:0] DPTC_OFS_P1_LOWER = 8'h2d;
    localparam logic [7:0] DPTC_OFS_INT_STATUS = 8'h40;
    localparam logic [7:0] DPTC_OFS_INT_MASK = 8'h41;

    // ==========================================================
    // Field positions
    localparam int DPTC_CTL_HOLD_BIT = 4;
    localparam int DPTC_STS_READY_BIT = 4;
    localparam int DPTC_CFG_EVENT_BIT = 0;
    localparam int DPTC_CFG_FREERUN_BIT = 1;
    localparam int DPTC_CFG_EARLY_BIT = 3;
    localparam int DPTC_CFG_RES_LSB = 4;
    localparam int DPTC_CFG_EDGE_BIT = 6;
    localparam logic [7:0] DPTC_CTL_WMASK = 8'h13;
    localparam logic [7:0] DPTC_CFG_WMASK = 8'h7b;
    localparam logic [7:0] DPTC_RESET_VALUE = 8'h00;

    // ==========================================================
    // Counter resolution, clock period 50 ns
    localparam int DPTC_CLK_NS = 50;
    localparam int DPTC_RES0_NS = 40;
    localparam int DPTC_RES1_NS = 80;
    localparam int DPTC_RES2_NS = 160;
    localparam int DPTC_RES3_NS = 1000;
    localparam int DPTC_RES0_CYC = (DPTC_RES0_NS + DPTC_CLK_NS - 1) / DPTC_CLK_NS;
    localparam int DPTC_RES1_CYC = (DPTC_RES1_NS + DPTC_CLK_NS - 1) / DPTC_CLK_NS;
    localparam int DPTC_RES2_CYC = (DPTC_RES2_NS + DPTC_CLK_NS - 1) / DPTC_CLK_NS;
    localparam int DPTC_RES3_CYC = (DPTC_RES3_NS + DPTC_CLK_NS - 1) / DPTC_CLK_NS;

    // ==========================================================
    // Interrupt event bits
    localparam int DPTC_EV_CAP0 = 0;
    localparam int DPTC_EV_CAP1 = 1;
    localparam int DPTC_EV_READY = 2;

endpackage : dptc_pkg

// ===== hw/dptc_tick.sv
// Purpose: Prescaler that yields the timestamp counter advance pulse.
// Assumes: Resolutions are rounded up to whole 50 ns clock cycles.
// Notes: A change of resolution restarts the prescale count.
`timescale 1ns/1ps
`default_nettype none
module dptc_tick
    import dptc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [1:0] res_sel,
    output logic tick
);
    logic [7:0] div_ff;
    logic [7:0] nxt_div;
    logic [1:0] sel_ff;
    logic [7:0] limit;

    // ==========================================================
    // Divide select
    assign limit = (res_sel == 2'h0) ? 8'(DPTC_RES0_CYC - 1) :
                   (res_sel == 2'h1) ? 8'(DPTC_RES1_CYC - 1) :
                   (res_sel == 2'h2) ? 8'(DPTC_RES2_CYC - 1) :
                   8'(DPTC_RES3_CYC - 1);
    assign tick = (div_ff >= limit);
    assign nxt_div = (tick || sel_ff != res_sel) ? 8'h00 : div_ff + 8'h01;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_ff <= 8'h00;
            sel_ff <= 2'h0;
        end else begin
            div_ff <= nxt_div;
            sel_ff <= res_sel;
        end
    end
endmodule : dptc_tick
`default_nettype wire

// ===== hw/dptc_top.sv
// Purpose: Two-port timestamp capture with hold, valid and ready reporting.
// Assumes: Line start inputs are synchronous one-cycle events; frame sync is a synchronous level.
// Notes: Read data appear the cycle after the read strobe.
// Functional notes
// - Writing hold one freezes captured values and clears ready at once.
// - Ready flag is read-only bit 4 of the capture status register.
// - Per-port enable bits 0 and 1 gate capturing for each port.
// - Line mode captures at the 16-bit trigger line from two byte registers.
// - Free-running frame mode arms frame watching at the trigger line.
// - Read-only valid flags per port in status bits 0 and 1.
// - Captured 16-bit values read through upper and lower byte registers.
// - Counter resolution selects 40, 80, 160 ns or 1 us, rounded up to 50, 100, 200 ns and 1 us.
// - Edge select chooses rising or falling frame sync edge.
// - Early ready raises ready when all ports have values.
`timescale 1ns/1ps
`default_nettype none
module dptc_top
    import dptc_pkg::*;
#(
    parameter int PORTS = 2
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [PORTS-1:0] line_start,
    input wire logic [PORTS-1:0] frame_sync,
    output logic irq
);
    // ==========================================================
    // Registers
    logic [7:0] control_ff;
    logic [7:0] config_ff;
    logic [7:0] line_upper_ff;
    logic [7:0] line_lower_ff;
    logic [15:0] counter_ff;
    logic [15:0] stamp_ff [PORTS];
    logic [PORTS-1:0] valid_ff;
    logic ready_ff;
    logic [7:0] rdata_ff;
    logic [2:0] int_status_ff;
    logic [2:0] int_mask_ff;
    logic [15:0] line_cnt_ff [PORTS];
    logic [PORTS-1:0] armed_ff;
    logic [PORTS-1:0] sync_prev_ff;

    // ==========================================================
    // Decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    logic wr_ctl, wr_cfg, wr_lup, wr_llo, rd_int;
    logic hold, early, event_frame, freerun, falling, tick;
    logic [1:0] res_sel;
    logic [15:0] trigger_line_number;
    logic [PORTS-1:0] port_enable;
    logic [PORTS-1:0] cap;
    logic [PORTS-1:0] fs_edge;
    logic all_valid;
    logic nxt_ready;
    logic ready_rise;
    logic [2:0] events;
    logic [2:0] nxt_int_status;
    logic [7:0] nxt_rdata;

    assign wr_ctl = reg_wr && hit(reg_addr, DPTC_OFS_CONTROL);
    assign wr_cfg = reg_wr && hit(reg_addr, DPTC_OFS_CONFIG);
    assign wr_lup = reg_wr && hit(reg_addr, DPTC_OFS_LINE_UPPER);
    assign wr_llo = reg_wr && hit(reg_addr, DPTC_OFS_LINE_LOWER);
    assign rd_int = reg_rd && hit(reg_addr, DPTC_OFS_INT_STATUS);

    assign hold = control_ff[DPTC_CTL_HOLD_BIT];
    assign port_enable = control_ff[PORTS-1:0];
    assign early = config_ff[DPTC_CFG_EARLY_BIT];
    assign event_frame = config_ff[DPTC_CFG_EVENT_BIT];
    assign freerun = config_ff[DPTC_CFG_FREERUN_BIT];
    assign falling = config_ff[DPTC_CFG_EDGE_BIT];
    assign res_sel = config_ff[DPTC_CFG_RES_LSB +: 2];
    assign trigger_line_number = {line_upper_ff, line_lower_ff};

    dptc_tick u_tick (
        .clk(clk),
        .rst(rst),
        .res_sel(res_sel),
        .tick(tick)
    );

    // ==========================================================
    // Counter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            counter_ff <= 16'h0000;
        end else if (tick) begin
            counter_ff <= counter_ff + 16'h0001;
        end
    end

    // ==========================================================
    // Per-port capture event
    genvar gi;
    generate
        for (gi = 0; gi < PORTS; gi++) begin : g_port
            logic [15:0] nxt_line;
            logic nxt_armed;
            // Frame sync edge detect on the selected polarity.
            assign fs_edge[gi] = falling ? (sync_prev_ff[gi] && !frame_sync[gi]) :
                                 (!sync_prev_ff[gi] && frame_sync[gi]);
            // Line count restarts on each frame edge; line starts advance it.
            assign nxt_line = fs_edge[gi] ? 16'h0000 :
                              (line_start[gi] ? line_cnt_ff[gi] + 16'h0001 : line_cnt_ff[gi]);
            // In free-running frame mode the watch arms once the trigger line passes.
            assign nxt_armed = fs_edge[gi] ? 1'b0 :
                               ((line_start[gi] && nxt_line == trigger_line_number)
                                ? 1'b1 : armed_ff[gi]);
            assign cap[gi] = port_enable[gi] && !hold &&
                             (event_frame ?
                              (fs_edge[gi] && (!freerun || armed_ff[gi])) :
                              (line_start[gi] && nxt_line == trigger_line_number));

            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    line_cnt_ff[gi] <= 16'h0000;
                    armed_ff[gi] <= 1'b0;
                    sync_prev_ff[gi] <= 1'b0;
                    stamp_ff[gi] <= 16'h0000;
                    valid_ff[gi] <= 1'b0;
                end else begin
                    line_cnt_ff[gi] <= nxt_line;
                    armed_ff[gi] <= nxt_armed;
                    sync_prev_ff[gi] <= frame_sync[gi];
                    if (cap[gi]) begin
                        stamp_ff[gi] <= counter_ff;
                        valid_ff[gi] <= 1'b1;
                    end
                end
            end
        end
    endgenerate

    // ==========================================================
    // Ready flag
    // Early mode needs every port valid; normal mode waits only on enabled ports.
    assign all_valid = early ? (&valid_ff) :
                       ((valid_ff & port_enable) == port_enable && |port_enable);
    assign nxt_ready = (wr_ctl && reg_wdata[DPTC_CTL_HOLD_BIT]) ? 1'b0 :
                       (hold ? 1'b0 : (all_valid ? 1'b1 : ready_ff));
    assign ready_rise = nxt_ready && !ready_ff;

    // ==========================================================
    // Interrupt status; set wins over the clearing read.
    assign events = {ready_rise, cap[1], cap[0]};
    assign nxt_int_status = (rd_int ? 3'h0 : int_status_ff) | events;
    assign irq = |(int_status_ff & int_mask_ff);

    // ==========================================================
    // Read mux
    assign nxt_rdata =
        hit(reg_addr, DPTC_OFS_CONFIG) ? config_ff :
        hit(reg_addr, DPTC_OFS_CONTROL) ? control_ff :
        hit(reg_addr, DPTC_OFS_LINE_UPPER) ? line_upper_ff :
        hit(reg_addr, DPTC_OFS_LINE_LOWER) ? line_lower_ff :
        hit(reg_addr, DPTC_OFS_STATUS) ?
            {3'h0, ready_ff, 2'h0, valid_ff} :
        hit(reg_addr, DPTC_OFS_P0_UPPER) ? stamp_ff[0][15:8] :
        hit(reg_addr, DPTC_OFS_P0_LOWER) ? stamp_ff[0][7:0] :
        hit(reg_addr, DPTC_OFS_P1_UPPER) ? stamp_ff[1][15:8] :
        hit(reg_addr, DPTC_OFS_P1_LOWER) ? stamp_ff[1][7:0] :
        hit(reg_addr, DPTC_OFS_INT_STATUS) ? {5'h00, int_status_ff} :
        hit(reg_addr, DPTC_OFS_INT_MASK) ? {5'h00, int_mask_ff} :
        8'h00;

    // ==========================================================
    // Register writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            control_ff <= DPTC_RESET_VALUE;
            config_ff <= DPTC_RESET_VALUE;
            line_upper_ff <= DPTC_RESET_VALUE;
            line_lower_ff <= DPTC_RESET_VALUE;
            ready_ff <= 1'b0;
            int_status_ff <= 3'h0;
            int_mask_ff <= 3'h0;
            rdata_ff <= 8'h00;
        end else begin
            if (wr_ctl) begin
                control_ff <= reg_wdata & DPTC_CTL_WMASK;
            end
            if (wr_cfg) begin
                config_ff <= reg_wdata & DPTC_CFG_WMASK;
            end
            if (wr_lup) begin
                line_upper_ff <= reg_wdata;
            end
            if (wr_llo) begin
                line_lower_ff <= reg_wdata;
            end
            if (reg_wr && hit(reg_addr, DPTC_OFS_INT_MASK)) begin
                int_mask_ff <= reg_wdata[2:0];
            end
            ready_ff <= nxt_ready;
            int_status_ff <= nxt_int_status;
            rdata_ff <= reg_rd ? nxt_rdata : 8'h00;
        end
    end

    assign reg_rdata = rdata_ff;
endmodule : dptc_top
`default_nettype wire

// ===== test/dptc_top_props.sv
// Purpose: Port-level checks for the dual port timestamp capture unit.
// Assumes: One clock, asynchronous active-high reset.
// Notes: Bound to every dptc_top instance.
`timescale 1ns/1ps
`default_nettype none
module dptc_top_props
    import dptc_pkg::*;
#(
    parameter int PORTS = 2
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [PORTS-1:0] line_start,
    input wire logic [PORTS-1:0] frame_sync,
    input wire logic irq
);
    // ====================
    // Register port
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Read data must be zero outside its slot, so several slaves can share one OR-ed bus.
    property p_rdata_idle;
        !$past(reg_rd) |-> reg_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data seen outside the read slot");

    property p_unmapped;
        reg_rd && reg_addr == 8'h30 |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped address returned data");

    property p_status_rsvd;
        reg_rd && reg_addr == DPTC_OFS_STATUS |=> reg_rdata[7:5] == 3'h0 && reg_rdata[3:2] == 2'h0;
    endproperty
    a_status_rsvd: assert property (p_status_rsvd)
        else $error("reserved status bits set");

    property p_int_rsvd;
        reg_rd && reg_addr == DPTC_OFS_INT_STATUS |=> reg_rdata[7:3] == 5'h00;
    endproperty
    a_int_rsvd: assert property (p_int_rsvd)
        else $error("reserved event bits set");

    property p_ctl_mask;
        reg_wr && reg_addr == DPTC_OFS_CONTROL ##1 reg_rd && reg_addr == DPTC_OFS_CONTROL
            |=> reg_rdata == ($past(reg_wdata, 2) & DPTC_CTL_WMASK);
    endproperty
    a_ctl_mask: assert property (p_ctl_mask)
        else $error("control read back differs from masked write");

    property p_line_up;
        reg_wr && reg_addr == DPTC_OFS_LINE_UPPER ##1 reg_rd && reg_addr == DPTC_OFS_LINE_UPPER
            |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_line_up: assert property (p_line_up)
        else $error("trigger line upper byte not kept");

    property p_line_lo;
        reg_wr && reg_addr == DPTC_OFS_LINE_LOWER ##1 reg_rd && reg_addr == DPTC_OFS_LINE_LOWER
            |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_line_lo: assert property (p_line_lo)
        else $error("trigger line lower byte not kept");

    property p_hold_ready;
        reg_wr && reg_addr == DPTC_OFS_CONTROL && reg_wdata[DPTC_CTL_HOLD_BIT]
            ##1 reg_rd && reg_addr == DPTC_OFS_STATUS |=> !reg_rdata[DPTC_STS_READY_BIT];
    endproperty
    a_hold_ready: assert property (p_hold_ready)
        else $error("ready still set right after hold");
endmodule : dptc_top_props

bind dptc_top dptc_top_props #(.PORTS(PORTS)) dptc_top_props_i (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .line_start(line_start), .frame_sync(frame_sync), .irq(irq)
);
`default_nettype wire

// ===== test/tb_top.sv
// Purpose: Register-level test of the dual port timestamp capture unit.
// Assumes: Every task starts right after a rising edge and ends right after one.
// Notes: Stamps are compared as port differences or with saved stamps, so the free counter phase never matters.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import dptc_pkg::*;
;
    logic clk, rst, reg_wr, reg_rd, irq;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic [1:0] line_start, frame_sync;
    logic [15:0] s0, s1, t0, t1;
    int err_count = 0;
    int comparisons = 0;
    int cyc [4] = '{DPTC_RES0_CYC, DPTC_RES1_CYC, DPTC_RES2_CYC, DPTC_RES3_CYC};

    dptc_top #(.PORTS(2)) dptc_top_i (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .line_start(line_start), .frame_sync(frame_sync), .irq(irq)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ====================
    // Access tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Idle cycles also drop a write strobe left high by the last write.
    task automatic step(input int n);
        repeat (n) begin
            reg_wr <= 1'b0;
            @(posedge clk);
        end
    endtask : step

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        v = reg_rdata;
        @(posedge clk);
    endtask : rd

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        rd(a, d);
        chk({8'h00, d}, {8'h00, e});
    endtask : rdc

    task automatic stamps();
        rd(DPTC_OFS_P0_UPPER, s0[15:8]);
        rd(DPTC_OFS_P0_LOWER, s0[7:0]);
        rd(DPTC_OFS_P1_UPPER, s1[15:8]);
        rd(DPTC_OFS_P1_LOWER, s1[7:0]);
    endtask : stamps

    task automatic pulse(input logic [1:0] m);
        line_start <= m;
        step(1);
        line_start <= 2'b00;
        step(1);
    endtask : pulse

    task automatic tog(input logic [1:0] m, input int gap);
        frame_sync <= frame_sync ^ m;
        step(gap);
    endtask : tog

    // Frame on rising sync, then line three reaches port 1 gap cycles after port 0.
    task automatic lines(input int gap);
        tog(2'b11, 3);
        pulse(2'b11);
        pulse(2'b11);
        pulse(2'b01);
        step(gap - 2);
        pulse(2'b10);
        tog(2'b11, 4);
    endtask : lines

    task automatic results();
        if (err_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results

    // ====================
    // Main sequence
    initial begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        line_start = 2'b00;
        frame_sync = 2'b00;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        step(1);
        for (int a = 8'h25; a <= 8'h2d; a++) begin
            rdc(8'(a), 8'h00);
        end
        rdc(DPTC_OFS_INT_STATUS, 8'h00);
        rdc(DPTC_OFS_INT_MASK, 8'h00);
        for (int a = 8'h29; a <= 8'h2d; a++) begin
            wr(8'(a), 8'hff);
            rdc(8'(a), 8'h00);
        end
        wr(8'h30, 8'hff);
        rdc(8'h30, 8'h00);
        wr(DPTC_OFS_CONFIG, 8'hff);
        rdc(DPTC_OFS_CONFIG, DPTC_CFG_WMASK);
        wr(DPTC_OFS_CONTROL, 8'hff);
        rdc(DPTC_OFS_CONTROL, 8'h13);
        wr(DPTC_OFS_LINE_UPPER, 8'ha5);
        rdc(DPTC_OFS_LINE_UPPER, 8'ha5);
        wr(DPTC_OFS_LINE_UPPER, 8'h00);
        wr(DPTC_OFS_LINE_LOWER, 8'h03);
        rdc(DPTC_OFS_LINE_LOWER, 8'h03);
        wr(DPTC_OFS_CONTROL, 8'h03);
        for (int c = 0; c < 4; c++) begin
            wr(DPTC_OFS_CONFIG, 8'(c << 4));
            lines(40);
            stamps();
            chk(s1 - s0, 16'(40 / cyc[c]));
        end
        rdc(DPTC_OFS_STATUS, 8'h13);
        chk({15'h0000, irq}, 16'h0000);
        wr(DPTC_OFS_INT_MASK, 8'h07);
        step(1);
        chk({15'h0000, irq}, 16'h0001);
        rdc(DPTC_OFS_INT_STATUS, 8'h07);
        chk({15'h0000, irq}, 16'h0000);
        wr(DPTC_OFS_CONTROL, 8'h13);
        rdc(DPTC_OFS_STATUS, 8'h03);
        t0 = s0;
        t1 = s1;
        lines(10);
        stamps();
        chk(s0, t0);
        chk(s1, t1);
        wr(DPTC_OFS_CONTROL, 8'h01);
        lines(10);
        stamps();
        chk(s1, t1);
        chk({15'h0000, s0 === t0}, 16'h0000);
        rdc(DPTC_OFS_STATUS, 8'h13);
        wr(DPTC_OFS_CONTROL, 8'h03);
        wr(DPTC_OFS_CONFIG, 8'h41);
        tog(2'b01, 40);
        tog(2'b10, 4);
        tog(2'b11, 4);
        stamps();
        chk(s1 - s0, 16'h0000);
        tog(2'b11, 4);
        tog(2'b01, 40);
        tog(2'b10, 4);
        stamps();
        chk(s1 - s0, 16'h0028);
        wr(DPTC_OFS_CONFIG, 8'h43);
        t0 = s0;
        t1 = s1;
        tog(2'b11, 4);
        pulse(2'b01);
        pulse(2'b01);
        pulse(2'b01);
        tog(2'b01, 40);
        tog(2'b10, 4);
        stamps();
        chk(s1, t1);
        chk({15'h0000, s0 === t0}, 16'h0000);
        // A mid-run reset is the only way to clear the valid flags again.
        // Early ready must then wait for the disabled port as well.
        rst <= 1'b1;
        step(2);
        rst <= 1'b0;
        step(1);
        rdc(DPTC_OFS_STATUS, 8'h00);
        chk({15'h0000, irq}, 16'h0000);
        wr(DPTC_OFS_LINE_LOWER, 8'h03);
        wr(DPTC_OFS_CONFIG, 8'h08);
        wr(DPTC_OFS_CONTROL, 8'h01);
        lines(10);
        rdc(DPTC_OFS_STATUS, 8'h01);
        wr(DPTC_OFS_CONTROL, 8'h03);
        lines(10);
        rdc(DPTC_OFS_STATUS, 8'h13);
        results();
    end
endmodule : tb_top
`default_nettype wire
